// *** src/opc_defs.svh ***
/*
 * Register indices, field positions, reset values and timing counts
 * for the oscillator and PLL control block.
 * Assumes a 100 MHz register clock; byte address is four times the index.
 */
`ifndef OPC_DEFS_SVH
`define OPC_DEFS_SVH
`define OPC_IDX_STATUS 6'h05
`define OPC_IDX_HFCTRL 6'h08
`define OPC_IDX_TRIM 6'h09
`define OPC_IDX_PLL 6'h10
`define OPC_IDX_O32 6'h18
`define OPC_IDX_X32 6'h1C
`define OPC_IDX_UNLOCK 6'h3F
`define OPC_UNLOCK_KEY 8'hD8
`define OPC_UNLOCK_CYC 4'hF
`define OPC_HF_RST 8'h0C
`define OPC_ZERO_RST 8'h00
`define OPC_HF_WMASK 8'hBD
`define OPC_PLL_WMASK 8'hC3
`define OPC_X32_WMASK 8'hB7
`define OPC_X32_LMASK 8'h83
`define OPC_RSB 7
`define OPC_PLL_SRC 6
`define OPC_HF_AUTO 0
`define OPC_X32_SEL 2
`define OPC_X32_LP 1
`define OPC_X32_EN 0
`define OPC_FSEL_RSVD 4'h4
`define OPC_FSEL_MAX 4'h9
`define OPC_MUL_X2 2'h1
`define OPC_MUL_X3 2'h2
`define OPC_HF_AVAIL 3'h2
`define OPC_PLL_AVAIL 3'h2
`define OPC_O32_AVAIL 3'h4
`define OPC_X32_AVAIL 3'h3
`define OPC_CRYSTAL_STARTUP_TIME_1K 17'h00400
`define OPC_CRYSTAL_STARTUP_TIME_16K 17'h04000
`define OPC_CRYSTAL_STARTUP_TIME_32K 17'h08000
`define OPC_CRYSTAL_STARTUP_TIME_64K 17'h10000
`define OPC_CLK_MHZ 100
`define OPC_TRIM_US 3
`define OPC_TRIM_MAX_CYC (`OPC_TRIM_US * `OPC_CLK_MHZ + 3)
`define OPC_TRIM_COPY 2'h3
`endif

// *** src/opc_pkg.sv ***
/*
 * Types shared by the oscillator control block and its helpers.
 * Assumes nothing beyond the constants header.
 */
package opc_pkg;
    typedef enum logic [1:0] {OPC_ACTIVE = 2'h0, OPC_IDLE = 2'h1, OPC_STANDBY = 2'h2, OPC_PDOWN = 2'h3} opc_sleep_t;
    typedef enum logic [1:0] {OPC_SRC_HF = 2'h0, OPC_SRC_O32 = 2'h1, OPC_SRC_X32 = 2'h2, OPC_SRC_PLL = 2'h3} opc_src_t;
    typedef enum logic [4:0] {
        OPC_OFF = 5'h01, OPC_WARM = 5'h02, OPC_READY = 5'h04, OPC_WAIT = 5'h08, OPC_GIVE = 5'h10
    } opc_gate_state_t;
    typedef struct packed {
        opc_gate_state_t st;
        logic [16:0] cnt;
        logic prev;
    } opc_gate_st_t;
    typedef struct packed {
        logic [7:0] hf_ctrl;
        logic [5:0] trim;
        logic [7:0] pll_ctrl;
        logic o32_rsb;
        logic [7:0] x32_ctrl;
        logic [3:0] unlock;
        logic [1:0] copy;
        logic auto_d;
        opc_src_t cur;
        logic switching;
        logic [3:0] run;
        logic [31:0] rdata;
    } opc_top_st_t;
endpackage : opc_pkg

// *** src/opc_sync2.sv ***
/*
 * Two-flop synchroniser for a group of levels from another clock.
 * Assumes the levels change slower than the register clock.
 */
`timescale 1ns/1ns
module opc_sync2 #(
    parameter int W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {logic [W-1:0] s1; logic [W-1:0] s2;} opc_sync_st_t;
    opc_sync_st_t q_r;
    opc_sync_st_t q_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        q_nxt.s1 = din;
        q_nxt.s2 = q_r.s1;
    end

    // Both stages clear on reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign dout = q_r.s2;
endmodule : opc_sync2

// *** src/opc_osc_gate.sv ***
/*
 * Start-up and delivery sequencer for one oscillator.
 * Assumes osc_lvl is already synchronised and slower than pclk / 2.
 */
`timescale 1ns/1ns
module opc_osc_gate (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic need,
    input wire logic osc_lvl,
    input wire logic [16:0] first_cnt,
    input wire logic [2:0] again_cnt,
    output logic stable,
    output logic avail
);
    import opc_pkg::*;
    opc_gate_st_t q_r;
    opc_gate_st_t q_nxt;
    logic tick;
    logic [16:0] inc;

    assign tick = osc_lvl & ~q_r.prev;
    assign inc = q_r.cnt + 17'h00001;

    // Warm-up counts oscillator edges once, delivery counts again per request.
    always_comb begin
        q_nxt = q_r;
        q_nxt.prev = osc_lvl;
        if (!run) begin
            q_nxt.st = OPC_OFF;
            q_nxt.cnt = '0;
        end else begin
            case (q_r.st)
                OPC_OFF: begin
                    q_nxt.cnt = '0;
                    q_nxt.st = (first_cnt == '0) ? OPC_READY : OPC_WARM;
                end
                OPC_WARM: begin
                    if (tick) begin
                        q_nxt.cnt = inc;
                        if (inc >= first_cnt) q_nxt.st = OPC_READY;
                    end
                end
                OPC_READY: begin
                    q_nxt.cnt = '0;
                    if (need) q_nxt.st = OPC_WAIT;
                end
                OPC_WAIT: begin
                    if (!need) begin
                        q_nxt.st = OPC_READY;
                    end else if (tick) begin
                        q_nxt.cnt = inc;
                        if (inc >= {14'h0000, again_cnt}) q_nxt.st = OPC_GIVE;
                    end
                end
                OPC_GIVE: begin
                    if (!need) q_nxt.st = OPC_READY;
                end
                default: q_nxt.st = OPC_OFF;
            endcase
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '{st: OPC_OFF, cnt: '0, prev: 1'b0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign stable = (q_r.st == OPC_READY) | (q_r.st == OPC_WAIT) | (q_r.st == OPC_GIVE);
    assign avail = (q_r.st == OPC_GIVE);
endmodule : opc_osc_gate

// *** src/opc_top.sv ***
/*
 * Oscillator and PLL configuration registers with run and delivery control.
 * Assumes an APB master on pclk, sleep mode and requests on pclk,
 * and raw oscillator levels from the analog side on osc_lvl.
 */
// What this block does
// - Switching flag high until new source delivering
// - Fast oscillator control resets to 0x0C
// - Frequency select codes; reserved codes refused
// - Fast oscillator runs on request or standby
// - Fast oscillator delivered after two cycles
// - Control bit zero enables crystal auto trim
// - Manual trim is signed six bit
// - Trim bits seven six mirror sign
// - Auto trim locks manual trim writes
// - Auto result copied into trim after disable
// - PLL runs on request or standby
// - PLL output delivered after two cycles
// - PLL control bit six selects reference
// - Multiplier zero disables, three is reserved
// - Slow internal oscillator run in standby
// - Slow internal delivered after four cycles
// - Crystal runs on request in active, idle
// - Crystal delivered within three cycles when warm
// - Start-up field sets crystal warm-up cycles
// - Start-up and source locked while enabled
// - Bit two picks crystal or external clock
// - Bit one enables crystal low power
`timescale 1ns/1ns
`include "opc_defs.svh"
module opc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire opc_pkg::opc_sleep_t sleep_mode,
    input wire opc_pkg::opc_src_t main_src_sel,
    input wire logic hf_req,
    input wire logic pll_req,
    input wire logic o32_req,
    input wire logic x32_req,
    input wire logic [5:0] autotrim_val,
    input wire logic [3:0] osc_lvl,
    output opc_pkg::opc_src_t main_src_cur,
    output logic main_source_switching,
    output logic hf_run,
    output logic hf_avail,
    output logic [3:0] frequency_select,
    output logic [5:0] hf_trim,
    output logic crystal_auto_trim_enable,
    output logic pll_run,
    output logic pll_avail,
    output logic pll_source,
    output logic [1:0] pll_multiplier,
    output logic o32_run,
    output logic o32_avail,
    output logic x32_run,
    output logic x32_avail,
    output logic x32_external_clock,
    output logic low_power_crystal
);
    import opc_pkg::*;
    localparam int TRIM_MAX = `OPC_TRIM_MAX_CYC;

    opc_top_st_t q_r;
    opc_top_st_t q_nxt;
    logic [3:0] lvl_s;
    logic [3:0] stable;
    logic [3:0] avail;
    logic [3:0] need;
    logic [3:0] main_need;
    logic [5:0] idx;
    logic acc_wr;
    logic setup;
    logic mapped;
    logic unlocked;
    logic pll_on;
    logic le_sb;
    logic le_idle;
    logic x32_lock;
    logic [16:0] x32_first;
    logic [3:0] fsel_w;
    logic [7:0] x32_mask;
    logic [7:0] wbyte;

    // Oscillator levels come from other clocks, so they are synchronised first.
    opc_sync2 #(.W(4)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(osc_lvl),
        .dout(lvl_s)
    );

    // Bus decode; the register index is the word address.
    assign idx = paddr[7:2];
    assign setup = psel & ~penable;
    assign acc_wr = psel & penable & pwrite & pstrb[0];
    assign wbyte = pwdata[7:0];
    assign unlocked = (q_r.unlock != 4'h0);
    always_comb begin
        if (idx == `OPC_IDX_STATUS) mapped = 1'b1;
        else if (idx == `OPC_IDX_HFCTRL) mapped = 1'b1;
        else if (idx == `OPC_IDX_TRIM) mapped = 1'b1;
        else if (idx == `OPC_IDX_PLL) mapped = 1'b1;
        else if (idx == `OPC_IDX_O32) mapped = 1'b1;
        else if (idx == `OPC_IDX_X32) mapped = 1'b1;
        else if (idx == `OPC_IDX_UNLOCK) mapped = 1'b1;
        else mapped = 1'b0;
    end

    // Sleep mode gates which oscillators may free-run.
    assign le_sb = (sleep_mode != OPC_PDOWN);
    assign le_idle = (sleep_mode == OPC_ACTIVE) | (sleep_mode == OPC_IDLE);
    assign pll_on = (q_r.pll_ctrl[1:0] == `OPC_MUL_X2) | (q_r.pll_ctrl[1:0] == `OPC_MUL_X3);

    // The main clock needs both the old and the new source during a switch.
    always_comb begin
        main_need = 4'h0;
        main_need[q_r.cur] = 1'b1;
        main_need[main_src_sel] = 1'b1;
    end

    // Requests per source; bit order is fast, slow internal, crystal, PLL.
    assign need[3] = pll_req | main_need[3];
    assign need[2] = (x32_req | main_need[2]) & le_idle;
    assign need[1] = o32_req | main_need[1];
    assign need[0] = hf_req | main_need[0] | (q_r.run[3] & ~q_r.pll_ctrl[`OPC_PLL_SRC]);

    // Start-up length only applies to a crystal; an external clock is ready at once.
    always_comb begin
        case (q_r.x32_ctrl[5:4])
            2'h0: x32_first = `OPC_CRYSTAL_STARTUP_TIME_1K;
            2'h1: x32_first = `OPC_CRYSTAL_STARTUP_TIME_16K;
            2'h2: x32_first = `OPC_CRYSTAL_STARTUP_TIME_32K;
            default: x32_first = `OPC_CRYSTAL_STARTUP_TIME_64K;
        endcase
        if (q_r.x32_ctrl[`OPC_X32_SEL]) x32_first = '0;
    end

    // Fast oscillator delivery after two of its cycles.
    opc_osc_gate u_hf (
        .pclk(pclk),
        .presetn(presetn),
        .run(q_r.run[0]),
        .need(need[0]),
        .osc_lvl(lvl_s[0]),
        .first_cnt(17'h00000),
        .again_cnt(`OPC_HF_AVAIL),
        .stable(stable[0]),
        .avail(avail[0])
    );

    // Slow internal oscillator delivery after four of its cycles.
    opc_osc_gate u_o32 (
        .pclk(pclk),
        .presetn(presetn),
        .run(q_r.run[1]),
        .need(need[1]),
        .osc_lvl(lvl_s[1]),
        .first_cnt(17'h00000),
        .again_cnt(`OPC_O32_AVAIL),
        .stable(stable[1]),
        .avail(avail[1])
    );

    // Crystal warms up once, then delivers within three cycles.
    opc_osc_gate u_x32 (
        .pclk(pclk),
        .presetn(presetn),
        .run(q_r.run[2]),
        .need(need[2]),
        .osc_lvl(lvl_s[2]),
        .first_cnt(x32_first),
        .again_cnt(`OPC_X32_AVAIL),
        .stable(stable[2]),
        .avail(avail[2])
    );

    // PLL delivery after two of its cycles; its source start-up is the requester's worry.
    opc_osc_gate u_pll (
        .pclk(pclk),
        .presetn(presetn),
        .run(q_r.run[3]),
        .need(need[3]),
        .osc_lvl(lvl_s[3]),
        .first_cnt(17'h00000),
        .again_cnt(`OPC_PLL_AVAIL),
        .stable(stable[3]),
        .avail(avail[3])
    );

    // Start-up and source bits freeze while the crystal is on or still stable.
    assign x32_lock = q_r.x32_ctrl[`OPC_X32_EN] | stable[2];
    assign x32_mask = x32_lock ? `OPC_X32_LMASK : `OPC_X32_WMASK;
    // A reserved frequency code is refused and the old code kept.
    assign fsel_w = ((wbyte[5:2] == `OPC_FSEL_RSVD) | (wbyte[5:2] > `OPC_FSEL_MAX)) ? q_r.hf_ctrl[5:2] : wbyte[5:2];

    // All register, switch and run state is computed here.
    always_comb begin
        q_nxt = q_r;
        q_nxt.unlock = unlocked ? q_r.unlock - 4'h1 : 4'h0;
        q_nxt.auto_d = q_r.hf_ctrl[`OPC_HF_AUTO];
        if (acc_wr) begin
            if (idx == `OPC_IDX_UNLOCK) begin
                if (wbyte == `OPC_UNLOCK_KEY) q_nxt.unlock = `OPC_UNLOCK_CYC;
            end else if (idx == `OPC_IDX_TRIM) begin
                if (!q_r.hf_ctrl[`OPC_HF_AUTO]) q_nxt.trim = wbyte[5:0];
            end else if (unlocked && idx == `OPC_IDX_HFCTRL) begin
                q_nxt.hf_ctrl = (wbyte & `OPC_HF_WMASK) | {2'h0, fsel_w, 2'h0};
                q_nxt.hf_ctrl[5:2] = fsel_w;
            end else if (unlocked && idx == `OPC_IDX_PLL) begin
                q_nxt.pll_ctrl = wbyte & `OPC_PLL_WMASK;
            end else if (unlocked && idx == `OPC_IDX_O32) begin
                q_nxt.o32_rsb = wbyte[`OPC_RSB];
            end else if (unlocked && idx == `OPC_IDX_X32) begin
                q_nxt.x32_ctrl = (wbyte & x32_mask) | (q_r.x32_ctrl & ~x32_mask);
            end
        end
        // Once auto trim is switched off, its last result lands in the trim register.
        if (q_r.auto_d && !q_r.hf_ctrl[`OPC_HF_AUTO]) q_nxt.copy = `OPC_TRIM_COPY;
        else if (q_r.copy != 2'h0) q_nxt.copy = q_r.copy - 2'h1;
        if (q_r.copy == 2'h1) q_nxt.trim = autotrim_val;
        // The main source only changes once the new one is delivering.
        if (main_src_sel != q_r.cur) begin
            q_nxt.switching = ~avail[main_src_sel];
            if (avail[main_src_sel]) q_nxt.cur = main_src_sel;
        end else begin
            q_nxt.switching = 1'b0;
        end
        q_nxt.run[0] = need[0] | (q_r.hf_ctrl[`OPC_RSB] & le_sb);
        q_nxt.run[1] = need[1] | q_r.o32_rsb;
        q_nxt.run[2] = q_r.x32_ctrl[`OPC_X32_EN] & (need[2] | q_r.x32_ctrl[`OPC_RSB]);
        q_nxt.run[3] = pll_on & (need[3] | (q_r.pll_ctrl[`OPC_RSB] & le_sb));
        // Read data is captured in the setup cycle so the access phase answers at once.
        if (setup) begin
            q_nxt.rdata = 32'h00000000;
            if (idx == `OPC_IDX_STATUS) q_nxt.rdata[7:0] = {2'h0, stable[3], 1'b0, stable[2], stable[1], stable[0], q_r.switching};
            else if (idx == `OPC_IDX_HFCTRL) q_nxt.rdata[7:0] = q_r.hf_ctrl;
            else if (idx == `OPC_IDX_TRIM) q_nxt.rdata[7:0] = {{2{q_r.trim[5]}}, q_r.trim};
            else if (idx == `OPC_IDX_PLL) q_nxt.rdata[7:0] = q_r.pll_ctrl;
            else if (idx == `OPC_IDX_O32) q_nxt.rdata[7:0] = {q_r.o32_rsb, 7'h00};
            else if (idx == `OPC_IDX_X32) q_nxt.rdata[7:0] = q_r.x32_ctrl;
            else if (idx == `OPC_IDX_UNLOCK) q_nxt.rdata[7:0] = {7'h00, unlocked};
        end
    end

    // State register; the fast oscillator control starts at its documented default.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '{hf_ctrl: `OPC_HF_RST, pll_ctrl: `OPC_ZERO_RST, x32_ctrl: `OPC_ZERO_RST, cur: OPC_SRC_HF,
                     default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs.
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = q_r.rdata;
    assign main_src_cur = q_r.cur;
    assign main_source_switching = q_r.switching;
    assign hf_run = q_r.run[0];
    assign o32_run = q_r.run[1];
    assign x32_run = q_r.run[2];
    assign pll_run = q_r.run[3];
    assign hf_avail = avail[0];
    assign o32_avail = avail[1];
    assign x32_avail = avail[2];
    assign pll_avail = avail[3];
    assign frequency_select = q_r.hf_ctrl[5:2];
    assign hf_trim = q_r.trim;
    assign crystal_auto_trim_enable = q_r.hf_ctrl[`OPC_HF_AUTO];
    assign pll_source = q_r.pll_ctrl[`OPC_PLL_SRC];
    assign pll_multiplier = q_r.pll_ctrl[1:0];
    assign x32_external_clock = q_r.x32_ctrl[`OPC_X32_SEL];
    assign low_power_crystal = q_r.x32_ctrl[`OPC_X32_LP];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_switch_flag_set: assert property ((main_src_sel != q_r.cur) && !avail[main_src_sel] |=> main_source_switching)
        else $error("switching flag not raised");
    a_fsel_code_legal: assert property ((frequency_select != `OPC_FSEL_RSVD) && (frequency_select <= `OPC_FSEL_MAX))
        else $error("reserved frequency code stored");
    a_trim_mirror_read: assert property (psel && penable && !pwrite && idx == `OPC_IDX_TRIM |-> prdata[7:6] == {2{prdata[5]}})
        else $error("trim sign not mirrored");
    a_trim_lock_auto: assert property (acc_wr && idx == `OPC_IDX_TRIM && crystal_auto_trim_enable && q_r.copy == 2'h0
        |=> $stable(hf_trim))
        else $error("trim changed while auto trim on");
    a_trim_copy_done: assert property ($fell(crystal_auto_trim_enable) ##1 (q_r.copy != 2'h0) [*3]
        |=> hf_trim == $past(autotrim_val))
        else $error("auto trim result not copied");
    a_pll_off_mul: assert property (!pll_on |=> !pll_run)
        else $error("pll runs with disabled multiplier");
    a_x32_cfg_lock: assert property (acc_wr && idx == `OPC_IDX_X32 && x32_lock |=> $stable(q_r.x32_ctrl[5:2]))
        else $error("crystal config changed while locked");
    a_protect_block: assert property (acc_wr && !unlocked && idx == `OPC_IDX_PLL |=> $stable(q_r.pll_ctrl))
        else $error("protected write accepted while locked");
    a_hf_request_run: assert property (hf_req |=> hf_run)
        else $error("fast oscillator not run on request");
    a_copy_bound: assert property ($fell(crystal_auto_trim_enable) |-> ##[1:TRIM_MAX] q_r.copy == 2'h0)
        else $error("trim copy too slow");

    c_switch_done: cover property (main_source_switching ##1 !main_source_switching);
    c_trim_copied: cover property (q_r.copy == 2'h1);
    c_unlock_write: cover property (acc_wr && unlocked && idx == `OPC_IDX_PLL);
    c_x32_avail: cover property ($rose(x32_avail));
endmodule : opc_top

// *** tb/opc_top_tb_top.sv ***
/*
 * Self-checking bench for the oscillator and PLL control block.
 * Assumes the block answers APB in its own time and a free-running oscillator level.
 */
`timescale 1ns/1ns
module opc_top_tb_top;
    import opc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr;
    logic [31:0] prdata, rv;
    opc_sleep_t sleep_mode = OPC_ACTIVE;
    opc_src_t main_src_sel = OPC_SRC_HF;
    opc_src_t main_src_cur;
    logic hf_req = 1'b0, pll_req = 1'b0, o32_req = 1'b0, x32_req = 1'b0;
    logic [5:0] autotrim_val = 6'h00;
    logic [3:0] osc_lvl = 4'h0;
    logic [2:0] div = 3'h0;
    logic main_source_switching, hf_run, hf_avail, crystal_auto_trim_enable, pll_run, pll_avail;
    logic pll_source, o32_run, o32_avail, x32_run, x32_avail, x32_external_clock, low_power_crystal;
    logic [3:0] frequency_select;
    logic [5:0] hf_trim;
    logic [1:0] pll_multiplier;
    int bad_count = 0;
    int checks = 0;
    int k;

    opc_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .pready, .prdata,
        .pslverr, .sleep_mode, .main_src_sel, .hf_req, .pll_req, .o32_req, .x32_req, .autotrim_val,
        .osc_lvl, .main_src_cur, .main_source_switching, .hf_run, .hf_avail, .frequency_select, .hf_trim,
        .crystal_auto_trim_enable, .pll_run, .pll_avail, .pll_source, .pll_multiplier, .o32_run,
        .o32_avail, .x32_run, .x32_avail, .x32_external_clock, .low_power_crystal);

    // The clock toggles every half period of 10 ns.
    always #5 pclk = ~pclk;

    // Oscillator levels run at one eighth of pclk, well under the synchroniser's limit.
    always @(posedge pclk) begin
        div <= div + 3'h1;
        osc_lvl <= {4{div[2]}};
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic [5:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge pclk);
        paddr <= {idx, 2'b00};
        pwrite <= wr;
        pwdata <= {24'h0, wd};
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // This wait ends when pready is seen high at an edge.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        if (wr === 1'b0) chk("pslverr", (idx == 6'h02), pslverr);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic uwr(input logic [5:0] idx, input logic [7:0] d);
        apb(6'h3F, 1'b1, 8'hD8);
        apb(idx, 1'b1, d);
    endtask : uwr

    task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
        apb(idx, 1'b0, 8'h00);
        chk("read data", {24'h0, exp}, rv);
    endtask : rd

    task automatic t_reset;
        rd(6'h08, 8'h0C);
        rd(6'h09, 8'h00);
        rd(6'h10, 8'h00);
        rd(6'h18, 8'h00);
        rd(6'h1C, 8'h00);
        rd(6'h02, 8'h00);
        chk("frequency_select", 4'h3, frequency_select);
        $display("test reset done");
    endtask : t_reset

    task automatic t_freq;
        logic [3:0] e;
        e = 4'h3;
        for (int c = 0; c < 16; c++) begin
            uwr(6'h08, {2'b00, c[3:0], 2'b00});
            e = (c == 4 || c > 9) ? e : c[3:0];
            @(posedge pclk);
            chk("frequency_select", e, frequency_select);
        end
        $display("test frequency done");
    endtask : t_freq

    task automatic t_trim;
        // Let the unlock window from the last scenario close, so the trim write proves it needs none.
        repeat (16) @(posedge pclk);
        apb(6'h09, 1'b1, 8'h60);
        rd(6'h09, 8'hE0);
        chk("hf_trim", 6'h20, hf_trim);
        apb(6'h09, 1'b1, 8'h9F);
        rd(6'h09, 8'h1F);
        uwr(6'h08, 8'h0D);
        @(posedge pclk);
        chk("auto trim", 1'b1, crystal_auto_trim_enable);
        apb(6'h09, 1'b1, 8'h05);
        rd(6'h09, 8'h1F);
        autotrim_val <= 6'h2A;
        uwr(6'h08, 8'h0C);
        for (k = 0; k < 303 && hf_trim !== 6'h2A; k++) @(posedge pclk);
        chk("hf_trim copy", 6'h2A, hf_trim);
        $display("test trim done");
    endtask : t_trim

    task automatic t_pll;
        // The unlock window must be shut before the unprotected write is tried.
        repeat (16) @(posedge pclk);
        apb(6'h10, 1'b1, 8'hC2);
        rd(6'h10, 8'h00);
        uwr(6'h10, 8'hC2);
        rd(6'h10, 8'hC2);
        chk("pll_source", 1'b1, pll_source);
        for (int m = 3; m >= 0; m--) begin
            uwr(6'h10, {6'h00, m[1:0]});
            @(posedge pclk);
            chk("pll_multiplier", m[1:0], pll_multiplier);
        end
        pll_req <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("pll_run off", 1'b0, pll_run);
        uwr(6'h10, 8'h01);
        for (k = 0; k < 200 && pll_avail !== 1'b1; k++) @(posedge pclk);
        chk("pll_avail", 1'b1, pll_avail);
        chk("pll_run", 1'b1, pll_run);
        pll_req <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("pll_avail drop", 1'b0, pll_avail);
        $display("test pll done");
    endtask : t_pll

    task automatic t_slow;
        uwr(6'h18, 8'h80);
        repeat (3) @(posedge pclk);
        chk("o32_run", 1'b1, o32_run);
        chk("o32_avail", 1'b0, o32_avail);
        o32_req <= 1'b1;
        for (k = 0; k < 200 && o32_avail !== 1'b1; k++) @(posedge pclk);
        chk("o32_avail", 1'b1, o32_avail);
        uwr(6'h1C, 8'h37);
        rd(6'h1C, 8'h37);
        chk("ext clock", 1'b1, x32_external_clock);
        chk("low power", 1'b1, low_power_crystal);
        uwr(6'h1C, 8'h01);
        rd(6'h1C, 8'h35);
        x32_req <= 1'b1;
        for (k = 0; k < 200 && x32_avail !== 1'b1; k++) @(posedge pclk);
        chk("x32_avail", 1'b1, x32_avail);
        chk("x32_run", 1'b1, x32_run);
        $display("test slow oscillators done");
    endtask : t_slow

    // Crystal mode with the shortest start-up: 1k edges at one per 8 clocks is about 8200 clocks.
    task automatic t_xtal;
        uwr(6'h1C, 8'h00);
        repeat (3) @(posedge pclk);
        uwr(6'h1C, 8'h01);
        rd(6'h1C, 8'h01);
        repeat (1000) @(posedge pclk);
        chk("x32 warming", 1'b0, x32_avail);
        for (k = 0; k < 9000 && x32_avail !== 1'b1; k++) @(posedge pclk);
        chk("x32_avail warm", 1'b1, x32_avail);
        rd(6'h05, 8'h0E);
        sleep_mode <= OPC_STANDBY;
        repeat (3) @(posedge pclk);
        chk("x32_run standby", 1'b0, x32_run);
        chk("hf_run standby", 1'b1, hf_run);
        sleep_mode <= OPC_ACTIVE;
        $display("test crystal done");
    endtask : t_xtal

    task automatic t_switch;
        // The target must not already be delivering, or the switch would finish at once.
        o32_req <= 1'b0;
        repeat (2) @(posedge pclk);
        hf_req <= 1'b1;
        main_src_sel <= OPC_SRC_O32;
        repeat (2) @(posedge pclk);
        chk("switching", 1'b1, main_source_switching);
        chk("main_src_cur old", OPC_SRC_HF, main_src_cur);
        for (k = 0; k < 200 && main_src_cur !== OPC_SRC_O32; k++) @(posedge pclk);
        chk("main_src_cur", OPC_SRC_O32, main_src_cur);
        chk("switching end", 1'b0, main_source_switching);
        chk("hf_avail", 1'b1, hf_avail);
        chk("hf_run", 1'b1, hf_run);
        $display("test switch done");
    endtask : t_switch

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up

    // Main sequence: reset for three cycles, then each scenario in turn.
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_freq();
        t_trim();
        t_pll();
        t_slow();
        t_xtal();
        t_switch();
        wrap_up();
    end

    // Watchdog sized well above the roughly nine thousand cycles the scenarios need.
    initial begin
        #300000;
        bad_count++;
        wrap_up();
    end
endmodule : opc_top_tb_top
